// file: src/smp_pkg.sv
/*
  package for the second-motor parameter bank: word addresses, reset values,
  legal limits and code values.
  assumes a word-addressed serial register master and 16-bit data.
*/
package smp_pkg;

  // word addresses of the bank
  localparam logic [15:0] SMP_A_FSRC    = 16'h2201;
  localparam logic [15:0] SMP_A_RSRC    = 16'h2202;
  localparam logic [15:0] SMP_A_BASE    = 16'h2203;
  localparam logic [15:0] SMP_A_MAXF    = 16'h2204;
  localparam logic [15:0] SMP_A_STEP_H  = 16'h2216;
  localparam logic [15:0] SMP_A_STEP_L  = 16'h2217;
  localparam logic [15:0] SMP_A_BMODE   = 16'h223B;
  localparam logic [15:0] SMP_A_BVOLT   = 16'h223C;
  localparam logic [15:0] SMP_A_BFREQ   = 16'h223D;
  localparam logic [15:0] SMP_A_VFC     = 16'h223E;
  localparam logic [15:0] SMP_A_VGAIN   = 16'h223F;
  localparam logic [15:0] SMP_A_ABVG    = 16'h2240;
  localparam logic [15:0] SMP_A_ABSG    = 16'h2241;
  localparam logic [15:0] SMP_A_ULIM_H  = 16'h224F;
  localparam logic [15:0] SMP_A_ULIM_L  = 16'h2250;
  localparam logic [15:0] SMP_A_LLIM_H  = 16'h2251;
  localparam logic [15:0] SMP_A_LLIM_L  = 16'h2252;
  localparam logic [15:0] SMP_A_VRMODE  = 16'h2269;
  localparam logic [15:0] SMP_A_VRSEL   = 16'h226A;
  localparam logic [15:0] SMP_A_ACC_H   = 16'h226F;
  localparam logic [15:0] SMP_A_ACC_L   = 16'h2270;

  // reset values (all inside their legal ranges for the low voltage class)
  localparam logic [15:0] SMP_RST_FSRC  = 16'h0002;
  localparam logic [15:0] SMP_RST_RSRC  = 16'h0002;
  localparam logic [15:0] SMP_RST_BASE  = 16'h0258;
  localparam logic [15:0] SMP_RST_MAXF  = 16'h0258;
  localparam logic [31:0] SMP_RST_STEP  = 32'h0000_0000;
  localparam logic [15:0] SMP_RST_BMODE = 16'h0000;
  localparam logic [15:0] SMP_RST_BVOLT = 16'h0064;
  localparam logic [15:0] SMP_RST_BFREQ = 16'h0005;
  localparam logic [15:0] SMP_RST_VFC   = 16'h0000;
  localparam logic [15:0] SMP_RST_VGAIN = 16'h0064;
  localparam logic [15:0] SMP_RST_ABVG  = 16'h0064;
  localparam logic [15:0] SMP_RST_ABSG  = 16'h0064;
  localparam logic [31:0] SMP_RST_ULIM  = 32'h0000_0000;
  localparam logic [31:0] SMP_RST_LLIM  = 32'h0000_0000;
  localparam logic [15:0] SMP_RST_VRMD  = 16'h0002;
  localparam logic [15:0] SMP_RST_VRSEL = 16'h0003;
  localparam logic [31:0] SMP_RST_ACC   = 32'h0000_03E8;

  // limits
  localparam logic [15:0] SMP_FREQ_MIN  = 16'h012C;    // 30.0 Hz in 0.1 Hz
  localparam logic [15:0] SMP_FREQ_MAX  = 16'h0FA0;    // 400.0 Hz in 0.1 Hz
  localparam logic [15:0] SMP_BV_MIN    = 16'h0014;
  localparam logic [15:0] SMP_BV_MAX    = 16'h00C8;
  localparam logic [15:0] SMP_BF_MAX    = 16'h0032;
  localparam logic [15:0] SMP_VG_MIN    = 16'h0014;
  localparam logic [15:0] SMP_VG_MAX    = 16'h0064;
  localparam logic [15:0] SMP_GAIN_MAX  = 16'h00FF;
  localparam logic [31:0] SMP_ACC_MIN   = 32'h0000_0001;
  localparam logic [31:0] SMP_ACC_MAX   = 32'h0005_7E40;  // 3600.00 s
  localparam logic [31:0] SMP_F_SCALE   = 32'h0000_000A;  // 0.1 Hz -> 0.01 Hz

  // code limits
  localparam logic [15:0] SMP_BMODE_MAX = 16'h0001;
  localparam logic [15:0] SMP_VFC_MAX   = 16'h0003;
  localparam logic [15:0] SMP_VRMD_MAX  = 16'h0002;
  localparam logic [15:0] SMP_VRLO_MAX  = 16'h0004;
  localparam logic [15:0] SMP_VRHI_MIN  = 16'h0005;
  localparam logic [15:0] SMP_VRHI_MAX  = 16'h000A;
  localparam logic [15:0] SMP_RSRC_MIN  = 16'h0001;
  localparam logic [15:0] SMP_RSRC_MAX  = 16'h0004;

  // frequency source codes
  localparam logic [15:0] SMP_FS_KEYPAD = 16'h0000;
  localparam logic [15:0] SMP_FS_TERM   = 16'h0001;
  localparam logic [15:0] SMP_FS_OPER   = 16'h0002;
  localparam logic [15:0] SMP_FS_BUS    = 16'h0003;
  localparam logic [15:0] SMP_FS_OPT    = 16'h0004;
  localparam logic [15:0] SMP_FS_PULSE  = 16'h0006;
  localparam logic [15:0] SMP_FS_PROG   = 16'h0007;
  localparam logic [15:0] SMP_FS_CALC   = 16'h000A;

  // whole state of the bank
  typedef struct packed {
    logic [15:0] fsrc;
    logic [15:0] rsrc;
    logic [15:0] base;
    logic [15:0] maxf;
    logic [31:0] step;
    logic [15:0] bmode;
    logic [15:0] bvolt;
    logic [15:0] bfreq;
    logic [15:0] vfc;
    logic [15:0] vgain;
    logic [15:0] abvg;
    logic [15:0] absg;
    logic [31:0] ulim;
    logic [31:0] llim;
    logic [15:0] vrmode;
    logic [15:0] vrsel;
    logic [31:0] acc;
    logic [15:0] step_hi;      // staged upper words
    logic [15:0] ulim_hi;
    logic [15:0] llim_hi;
    logic [15:0] acc_hi;
    logic        ack;
    logic [15:0] rdata;
    logic        addr_err;
    logic        val_err;
  } smp_state_t;

endpackage

// file: src/smp_bank.sv
/*
  second-motor parameter bank: sixteen-bit word registers with range checks
  and staged two-word commits for the 32-bit settings.
  assumes one word request at a time from a serial register master,
  synchronous to clk; start frequency and voltage class come from outside.
*/
// Contract
// [R01] frequency source takes 0,1,2,3,4,6,7,10
// [R02] run source takes codes 1 to 4
// [R03] base 300..max, max 300..4000
// [R04] step speed zero: 32-bit, 0 or start..max
// [R05] boost mode takes manual or automatic
// [R06] boost voltage takes 20 to 200
// [R07] boost frequency takes 0 to 50
// [R08] curve select takes codes 0 to 3
// [R09] output voltage gain takes 20 to 100
// [R10] both boost gains take 0 to 255
// [R11] upper limit: 0 or lower..max
// [R12] lower limit: 0 or start..max
// [R13] regulation mode takes codes 0 to 2
// [R14] voltage code 0-4 low, 5-10 high class
// [R15] acceleration time two: 1 to 360000
// [R16] reserved addresses error, writes ignored
// [R17] out-of-range writes rejected, value kept
`timescale 1ns/100ps
module smp_bank (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // word register port
  input  wire logic        req,
  input  wire logic        we,
  input  wire logic [15:0] addr,
  input  wire logic [15:0] wdata,
  output logic             ack,
  output logic      [15:0] rdata,
  output logic             addr_err,
  output logic             val_err,
  // context from the rest of the drive
  input  wire logic [15:0] start_freq,
  input  wire logic        high_volt_class,
  // settings towards motor control
  output logic      [15:0] freq_source_select_m2,
  output logic      [15:0] run_source_select_m2,
  output logic      [15:0] base_frequency_m2,
  output logic      [15:0] max_frequency_m2,
  output logic      [31:0] step_speed0_m2,
  output logic      [15:0] boost_mode_m2,
  output logic      [15:0] boost_voltage_m2,
  output logic      [15:0] manual_boost_freq_m2,
  output logic      [15:0] volt_freq_curve_m2,
  output logic      [15:0] output_voltage_gain_m2,
  output logic      [15:0] auto_boost_volt_gain_m2,
  output logic      [15:0] auto_boost_slip_gain_m2,
  output logic      [31:0] freq_upper_limit_m2,
  output logic      [31:0] freq_lower_limit_m2,
  output logic      [15:0] voltage_regulator_mode_m2,
  output logic      [15:0] regulated_voltage_select_m2,
  output logic      [31:0] accel_time2_m2
);
  import smp_pkg::*;

  smp_state_t st_r;     // registered state
  smp_state_t st_nxt;   // next state

  // closed range test used by the 16-bit fields with a nonzero lower bound
  function automatic logic in16(input logic [15:0] v, input logic [15:0] lo,
                                input logic [15:0] hi);
    in16 = (v >= lo) && (v <= hi);
  endfunction

  // zero, or inside lo..hi; used by the 0.01 Hz settings
  function automatic logic zero_or(input logic [31:0] v, input logic [31:0] lo,
                                   input logic [31:0] hi);
    zero_or = (v == 32'h0000_0000) || ((v >= lo) && (v <= hi));
  endfunction

  // address is one of the mapped words
  function automatic logic mapped(input logic [15:0] a);
    case (a)
      SMP_A_FSRC, SMP_A_RSRC, SMP_A_BASE, SMP_A_MAXF, SMP_A_STEP_H,
      SMP_A_STEP_L, SMP_A_BMODE, SMP_A_BVOLT, SMP_A_BFREQ, SMP_A_VFC,
      SMP_A_VGAIN, SMP_A_ABVG, SMP_A_ABSG, SMP_A_ULIM_H, SMP_A_ULIM_L,
      SMP_A_LLIM_H, SMP_A_LLIM_L, SMP_A_VRMODE, SMP_A_VRSEL, SMP_A_ACC_H,
      SMP_A_ACC_L: mapped = 1'b1;
      default:     mapped = 1'b0;
    endcase
  endfunction

  logic [31:0] maxf_fine;  // maximum frequency in 0.01 Hz
  logic [31:0] wide_wr;    // staged upper word joined with the low word
  logic [15:0] hi_sel;     // staged upper word of the addressed pair
  logic        ok;         // write value passes its check
  logic        vr_ok;      // voltage code fits the class

  assign maxf_fine = 32'({16'h0000, st_r.maxf} * SMP_F_SCALE);

  // pick the staged upper word matching a low-word address
  always_comb begin
    case (addr)
      SMP_A_STEP_L: hi_sel = st_r.step_hi;
      SMP_A_ULIM_L: hi_sel = st_r.ulim_hi;
      SMP_A_LLIM_L: hi_sel = st_r.llim_hi;
      default:      hi_sel = st_r.acc_hi;
    endcase
  end
  assign wide_wr = {hi_sel, wdata};

  // voltage code must belong to the fitted class
  assign vr_ok = high_volt_class ? in16(wdata, SMP_VRHI_MIN, SMP_VRHI_MAX)
                                 : (wdata <= SMP_VRLO_MAX);  // see [R14]

  // value check per address; upper words only stage, so always pass
  always_comb begin
    case (addr)
      SMP_A_FSRC: begin
        ok = (wdata == SMP_FS_KEYPAD) || (wdata == SMP_FS_TERM) ||
             (wdata == SMP_FS_OPER) || (wdata == SMP_FS_BUS) ||
             (wdata == SMP_FS_OPT) || (wdata == SMP_FS_PULSE) ||
             (wdata == SMP_FS_PROG) || (wdata == SMP_FS_CALC);  // see [R01]
      end
      SMP_A_RSRC:   ok = in16(wdata, SMP_RSRC_MIN, SMP_RSRC_MAX);  // see [R02]
      SMP_A_BASE:   ok = in16(wdata, SMP_FREQ_MIN, st_r.maxf);     // see [R03]
      SMP_A_MAXF:   ok = in16(wdata, SMP_FREQ_MIN, SMP_FREQ_MAX);  // see [R03]
      SMP_A_STEP_L: begin
        ok = zero_or(wide_wr, {16'h0000, start_freq}, maxf_fine);  // see [R04]
      end
      SMP_A_BMODE:  ok = (wdata <= SMP_BMODE_MAX);                 // see [R05]
      SMP_A_BVOLT:  ok = in16(wdata, SMP_BV_MIN, SMP_BV_MAX);      // see [R06]
      SMP_A_BFREQ:  ok = (wdata <= SMP_BF_MAX);                    // see [R07]
      SMP_A_VFC:    ok = (wdata <= SMP_VFC_MAX);                   // see [R08]
      SMP_A_VGAIN:  ok = in16(wdata, SMP_VG_MIN, SMP_VG_MAX);      // see [R09]
      SMP_A_ABVG,
      SMP_A_ABSG:   ok = (wdata <= SMP_GAIN_MAX);                  // see [R10]
      SMP_A_ULIM_L: ok = zero_or(wide_wr, st_r.llim, maxf_fine);   // see [R11]
      SMP_A_LLIM_L: begin
        ok = zero_or(wide_wr, {16'h0000, start_freq}, maxf_fine);  // see [R12]
      end
      SMP_A_VRMODE: ok = (wdata <= SMP_VRMD_MAX);                  // see [R13]
      SMP_A_VRSEL:  ok = vr_ok;
      SMP_A_ACC_L: begin
        ok = (wide_wr >= SMP_ACC_MIN) && (wide_wr <= SMP_ACC_MAX);  // see [R15]
      end
      default:      ok = 1'b1;
    endcase
  end

  // next state: answer every request one cycle later
  always_comb begin
    st_nxt          = st_r;
    st_nxt.ack      = req;
    st_nxt.addr_err = req && !mapped(addr);  // see [R16]
    st_nxt.val_err  = 1'b0;
    st_nxt.rdata    = 16'h0000;
    if (req && mapped(addr) && we) begin
      // rejected writes keep the stored value
      st_nxt.val_err = !ok;  // see [R17]
      if (ok) begin
        case (addr)
          SMP_A_FSRC:   st_nxt.fsrc    = wdata;
          SMP_A_RSRC:   st_nxt.rsrc    = wdata;
          SMP_A_BASE:   st_nxt.base    = wdata;
          SMP_A_MAXF:   st_nxt.maxf    = wdata;
          SMP_A_STEP_H: st_nxt.step_hi = wdata;
          SMP_A_STEP_L: st_nxt.step    = wide_wr;  // see [R04]
          SMP_A_BMODE:  st_nxt.bmode   = wdata;
          SMP_A_BVOLT:  st_nxt.bvolt   = wdata;
          SMP_A_BFREQ:  st_nxt.bfreq   = wdata;
          SMP_A_VFC:    st_nxt.vfc     = wdata;
          SMP_A_VGAIN:  st_nxt.vgain   = wdata;
          SMP_A_ABVG:   st_nxt.abvg    = wdata;
          SMP_A_ABSG:   st_nxt.absg    = wdata;
          SMP_A_ULIM_H: st_nxt.ulim_hi = wdata;
          SMP_A_ULIM_L: st_nxt.ulim    = wide_wr;  // see [R11]
          SMP_A_LLIM_H: st_nxt.llim_hi = wdata;
          SMP_A_LLIM_L: st_nxt.llim    = wide_wr;  // see [R12]
          SMP_A_VRMODE: st_nxt.vrmode  = wdata;
          SMP_A_VRSEL:  st_nxt.vrsel   = wdata;
          SMP_A_ACC_H:  st_nxt.acc_hi  = wdata;
          SMP_A_ACC_L:  st_nxt.acc     = wide_wr;  // see [R15]
          default:      st_nxt.fsrc    = st_r.fsrc;
        endcase
      end
    end else if (req && mapped(addr)) begin
      // reads return committed values, never the staged words
      case (addr)
        SMP_A_FSRC:   st_nxt.rdata = st_r.fsrc;
        SMP_A_RSRC:   st_nxt.rdata = st_r.rsrc;
        SMP_A_BASE:   st_nxt.rdata = st_r.base;
        SMP_A_MAXF:   st_nxt.rdata = st_r.maxf;
        SMP_A_STEP_H: st_nxt.rdata = st_r.step[31:16];
        SMP_A_STEP_L: st_nxt.rdata = st_r.step[15:0];
        SMP_A_BMODE:  st_nxt.rdata = st_r.bmode;
        SMP_A_BVOLT:  st_nxt.rdata = st_r.bvolt;
        SMP_A_BFREQ:  st_nxt.rdata = st_r.bfreq;
        SMP_A_VFC:    st_nxt.rdata = st_r.vfc;
        SMP_A_VGAIN:  st_nxt.rdata = st_r.vgain;
        SMP_A_ABVG:   st_nxt.rdata = st_r.abvg;
        SMP_A_ABSG:   st_nxt.rdata = st_r.absg;
        SMP_A_ULIM_H: st_nxt.rdata = st_r.ulim[31:16];
        SMP_A_ULIM_L: st_nxt.rdata = st_r.ulim[15:0];
        SMP_A_LLIM_H: st_nxt.rdata = st_r.llim[31:16];
        SMP_A_LLIM_L: st_nxt.rdata = st_r.llim[15:0];
        SMP_A_VRMODE: st_nxt.rdata = st_r.vrmode;
        SMP_A_VRSEL:  st_nxt.rdata = st_r.vrsel;
        SMP_A_ACC_H:  st_nxt.rdata = st_r.acc[31:16];
        SMP_A_ACC_L:  st_nxt.rdata = st_r.acc[15:0];
        default:      st_nxt.rdata = 16'h0000;
      endcase
    end
  end

  // state register; reset loads defaults legal for the low voltage class only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r          <= '0;
      st_r.fsrc     <= SMP_RST_FSRC;
      st_r.rsrc     <= SMP_RST_RSRC;
      st_r.base     <= SMP_RST_BASE;
      st_r.maxf     <= SMP_RST_MAXF;
      st_r.step     <= SMP_RST_STEP;
      st_r.bmode    <= SMP_RST_BMODE;
      st_r.bvolt    <= SMP_RST_BVOLT;
      st_r.bfreq    <= SMP_RST_BFREQ;
      st_r.vfc      <= SMP_RST_VFC;
      st_r.vgain    <= SMP_RST_VGAIN;
      st_r.abvg     <= SMP_RST_ABVG;
      st_r.absg     <= SMP_RST_ABSG;
      st_r.ulim     <= SMP_RST_ULIM;
      st_r.llim     <= SMP_RST_LLIM;
      st_r.vrmode   <= SMP_RST_VRMD;
      st_r.vrsel    <= SMP_RST_VRSEL;
      st_r.acc      <= SMP_RST_ACC;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register
  assign ack                         = st_r.ack;
  assign rdata                       = st_r.rdata;
  assign addr_err                    = st_r.addr_err;
  assign val_err                     = st_r.val_err;
  assign freq_source_select_m2       = st_r.fsrc;
  assign run_source_select_m2        = st_r.rsrc;
  assign base_frequency_m2           = st_r.base;
  assign max_frequency_m2            = st_r.maxf;
  assign step_speed0_m2              = st_r.step;
  assign boost_mode_m2               = st_r.bmode;
  assign boost_voltage_m2            = st_r.bvolt;
  assign manual_boost_freq_m2        = st_r.bfreq;
  assign volt_freq_curve_m2          = st_r.vfc;
  assign output_voltage_gain_m2      = st_r.vgain;
  assign auto_boost_volt_gain_m2     = st_r.abvg;
  assign auto_boost_slip_gain_m2     = st_r.absg;
  assign freq_upper_limit_m2         = st_r.ulim;
  assign freq_lower_limit_m2         = st_r.llim;
  assign voltage_regulator_mode_m2   = st_r.vrmode;
  assign regulated_voltage_select_m2 = st_r.vrsel;
  assign accel_time2_m2              = st_r.acc;

endmodule

// file: verification/smp_bank_asserts.sv
/*
  port checker for the second-motor parameter bank.
  assumes it is bound to smp_bank and that the bank has one clock domain.
*/
`timescale 1ns/100ps
module smp_bank_asserts
  import smp_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // word register port
  input wire logic        req,
  input wire logic        we,
  input wire logic [15:0] addr,
  input wire logic [15:0] wdata,
  input wire logic        ack,
  input wire logic [15:0] rdata,
  input wire logic        addr_err,
  input wire logic        val_err,
  // settings watched
  input wire logic [15:0] freq_source_select_m2,
  input wire logic [15:0] run_source_select_m2,
  input wire logic [15:0] boost_voltage_m2,
  input wire logic [15:0] auto_boost_volt_gain_m2
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // true for every word the bank answers without an address error
  function automatic logic mapped(input logic [15:0] a);
    mapped = a inside {[16'h2201:16'h2204], 16'h2216, 16'h2217, [16'h223B:16'h2241],
                       [16'h224F:16'h2252], 16'h2269, 16'h226A, 16'h226F, 16'h2270};
  endfunction

  // a write request taken at one register
  sequence s_wr(a);
    req && we && addr == a;
  endsequence
  // the answer cycle of an accepted write
  sequence s_ok;
    ack && !val_err && !addr_err;
  endsequence

  a_ack_follows: assert property (req |=> ack) else $error("no ack after request");
  a_ack_only_req: assert property (!req |=> !ack) else $error("ack without request");
  a_gap_flagged: assert property (req && !mapped(addr) |=>
    addr_err && !val_err && rdata == 16'h0000) else $error("unmapped access not flagged");
  a_map_clean: assert property (req && mapped(addr) |=> !addr_err) else $error("mapped word flagged");
  a_run_code_kept: assert property (s_wr(SMP_A_RSRC) ##0 (wdata == 16'h0000 || wdata > 16'h0004)
    |=> val_err ##0 $stable(run_source_select_m2)) else $error("bad run code taken");
  a_fsrc_code_ok: assert property (s_wr(SMP_A_FSRC) ##0 wdata inside {16'h0000, 16'h0001,
    16'h0002, 16'h0003, 16'h0004, 16'h0006, 16'h0007, 16'h000A}
    |=> s_ok ##0 freq_source_select_m2 == $past(wdata)) else $error("good source code refused");
  a_boost_range: assert property (s_wr(SMP_A_BVOLT) ##0 (wdata < 16'h0014 || wdata > 16'h00C8)
    |=> val_err ##0 $stable(boost_voltage_m2)) else $error("boost voltage out of range taken");
  a_gain_commit: assert property (s_wr(SMP_A_ABVG) ##0 wdata <= 16'h00FF
    |=> s_ok ##0 auto_boost_volt_gain_m2 == $past(wdata)) else $error("gain write lost");
  a_write_no_data: assert property (req && we |=> rdata == 16'h0000) else $error("data on write");
endmodule

bind smp_bank smp_bank_asserts u_chk (.clk, .rst, .req, .we, .addr, .wdata, .ack, .rdata,
  .addr_err, .val_err, .freq_source_select_m2, .run_source_select_m2, .boost_voltage_m2,
  .auto_boost_volt_gain_m2);

// file: verification/smp_master.sv
/*
  behavioural serial register master for the parameter bank.
  assumes one word access at a time, answered one cycle after the request.
*/
`timescale 1ns/100ps
module smp_master (
  // clock
  input  wire logic        clk,
  // request side
  output logic             req,
  output logic             we,
  output logic      [15:0] addr,
  output logic      [15:0] wdata,
  // answer side
  input  wire logic        ack,
  input  wire logic [15:0] rdata,
  input  wire logic        addr_err,
  input  wire logic        val_err
);
  initial begin
    req   = 1'b0;
    we    = 1'b0;
    addr  = 16'h0000;
    wdata = 16'h0000;
  end

  // one word access; idle lines carry the inverse so stale values never count
  task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
                      output logic [15:0] rd, output logic ae, output logic ve, output logic ak);
    @(posedge clk);
    req   <= 1'b1;
    we    <= w;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    req   <= 1'b0;
    we    <= ~w;
    addr  <= ~a;
    wdata <= ~d;
    // the answer stands for the following cycle; take it at its sampling edge
    @(posedge clk);
    ak = ack;
    rd = rdata;
    ae = addr_err;
    ve = val_err;
  endtask
endmodule

// file: verification/smp_bank_tb_top.sv
/*
  self-checking bench for the second-motor parameter bank.
  assumes smp_bank, smp_master and the bound checker are compiled alongside.
*/
`timescale 1ns/100ps
module smp_bank_tb_top;
  import smp_pkg::*;
  logic        clk = 1'b0;
  logic        rst, req, we, ack, addr_err, val_err, high_volt_class;
  logic [15:0] addr, wdata, rdata, start_freq, rd;
  logic [31:0] step_speed0_m2, accel_time2_m2;
  logic        ae, ve, ak;
  int          err_count = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  always #25 clk = ~clk;

  smp_master m (.clk(clk), .req(req), .we(we), .addr(addr), .wdata(wdata), .ack(ack),
    .rdata(rdata), .addr_err(addr_err), .val_err(val_err));
  smp_bank DUT (.clk(clk), .rst(rst), .req(req), .we(we), .addr(addr), .wdata(wdata),
    .ack(ack), .rdata(rdata), .addr_err(addr_err), .val_err(val_err),
    .start_freq(start_freq), .high_volt_class(high_volt_class),
    .freq_source_select_m2(), .run_source_select_m2(), .base_frequency_m2(),
    .max_frequency_m2(), .step_speed0_m2(step_speed0_m2), .boost_mode_m2(),
    .boost_voltage_m2(), .manual_boost_freq_m2(), .volt_freq_curve_m2(),
    .output_voltage_gain_m2(), .auto_boost_volt_gain_m2(), .auto_boost_slip_gain_m2(),
    .freq_upper_limit_m2(), .freq_lower_limit_m2(), .voltage_regulator_mode_m2(),
    .regulated_voltage_select_m2(), .accel_time2_m2(accel_time2_m2));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic bad);
    m.xfer(1'b1, a, d, rd, ae, ve, ak);
    check("write answer", {ak, ae, ve, rd}, {2'h2, bad, 16'h0000});
  endtask
  task automatic rdc(input logic [15:0] a, input logic [15:0] e);
    m.xfer(1'b0, a, 16'h0000, rd, ae, ve, ak);
    check("read word", {ak, ae, ve, rd}, {3'h4, e});
  endtask
  // walk codes 0..n; illegal ones must leave the stored code alone
  task automatic code(input logic [15:0] a, input logic [15:0] e, input int n,
                      input logic [15:0] ok);
    for (int v = 0; v <= n; v++) begin
      wr(a, 16'(v), !ok[v]);
      if (ok[v]) e = 16'(v);
      rdc(a, e);
    end
  endtask
  // both edges of a range, one step above hi, and one step below lo when lo is nonzero
  task automatic bound(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
    if (lo != 16'h0000) wr(a, lo - 16'h0001, 1'b1);
    wr(a, hi + 16'h0001, 1'b1);
    wr(a, lo, 1'b0);
    rdc(a, lo);
    wr(a, hi, 1'b0);
    rdc(a, hi);
  endtask
  // upper word staged first, lower word checks and commits
  task automatic w32(input logic [15:0] ah, input logic [31:0] v, input logic bad);
    wr(ah, v[31:16], 1'b0);
    wr(ah + 16'h0001, v[15:0], bad);
  endtask

  task automatic t_reset();
    logic [15:0] ra [10];
    logic [15:0] rv [10];
    ra = '{SMP_A_FSRC, SMP_A_RSRC, SMP_A_BASE, SMP_A_BVOLT, SMP_A_BFREQ, SMP_A_VGAIN,
           SMP_A_ABSG, SMP_A_VRMODE, SMP_A_VRSEL, SMP_A_ACC_L};
    rv = '{SMP_RST_FSRC, SMP_RST_RSRC, SMP_RST_BASE, SMP_RST_BVOLT, SMP_RST_BFREQ,
           SMP_RST_VGAIN, SMP_RST_ABSG, SMP_RST_VRMD, SMP_RST_VRSEL, SMP_RST_ACC[15:0]};
    foreach (ra[i]) rdc(ra[i], rv[i]);
  endtask

  task automatic t_codes();
    code(SMP_A_FSRC, SMP_RST_FSRC, 11, 16'h04DF);
    code(SMP_A_RSRC, SMP_RST_RSRC, 5, 16'h001E);
    code(SMP_A_BMODE, SMP_RST_BMODE, 2, 16'h0003);
    code(SMP_A_VFC, SMP_RST_VFC, 4, 16'h000F);
    code(SMP_A_VRMODE, SMP_RST_VRMD, 3, 16'h0007);
    code(SMP_A_VRSEL, SMP_RST_VRSEL, 11, 16'h001F);
    @(posedge clk) high_volt_class <= 1'b1;
    code(SMP_A_VRSEL, 16'h0004, 11, 16'h07E0);
  endtask

  task automatic t_ranges();
    bound(SMP_A_MAXF, 16'h012C, 16'h0FA0);
    bound(SMP_A_BASE, 16'h012C, 16'h0FA0);
    wr(SMP_A_MAXF, 16'h012C, 1'b0);
    wr(SMP_A_BASE, 16'h012D, 1'b1);
    wr(SMP_A_MAXF, 16'h0FA0, 1'b0);
    bound(SMP_A_BVOLT, 16'h0014, 16'h00C8);
    bound(SMP_A_BFREQ, 16'h0000, 16'h0032);
    bound(SMP_A_VGAIN, 16'h0014, 16'h0064);
    bound(SMP_A_ABVG, 16'h0000, 16'h00FF);
    bound(SMP_A_ABSG, 16'h0000, 16'h00FF);
  endtask

  // start 1.00 Hz, max 400.0 Hz gives a 0.01 Hz ceiling of 0x9C40
  task automatic t_wide();
    w32(SMP_A_STEP_H, 32'h0000_0063, 1'b1);
    w32(SMP_A_STEP_H, 32'h0000_9C41, 1'b1);
    w32(SMP_A_STEP_H, 32'h0000_9C40, 1'b0);
    check("step port", step_speed0_m2, 32'h0000_9C40);
    wr(SMP_A_STEP_H, 16'h0001, 1'b0);
    rdc(SMP_A_STEP_H, 16'h0000);
    wr(SMP_A_STEP_L, 16'h0000, 1'b1);
    w32(SMP_A_LLIM_H, 32'h0000_0063, 1'b1);
    w32(SMP_A_LLIM_H, 32'h0000_0064, 1'b0);
    w32(SMP_A_ULIM_H, 32'h0000_0063, 1'b1);
    w32(SMP_A_ULIM_H, 32'h0000_0064, 1'b0);
    w32(SMP_A_ULIM_H, 32'h0000_0000, 1'b0);
    w32(SMP_A_ACC_H, 32'h0005_7E40, 1'b0);
    check("accel port", accel_time2_m2, 32'h0005_7E40);
    w32(SMP_A_ACC_H, 32'h0005_7E41, 1'b1);
    w32(SMP_A_ACC_H, 32'h0000_0000, 1'b1);
    w32(SMP_A_ACC_H, 32'h0000_0001, 1'b0);
    rdc(SMP_A_ACC_H, 16'h0000);
  endtask

  task automatic t_gaps();
    logic [15:0] g [8];
    g = '{16'h2200, 16'h2205, 16'h2215, 16'h2218, 16'h2242, 16'h2253, 16'h226B, 16'h2271};
    foreach (g[i]) begin
      m.xfer(1'b1, g[i], 16'h0001, rd, ae, ve, ak);
      check("gap write", {ak, ae, ve, rd}, {3'h6, 16'h0000});
      m.xfer(1'b0, g[i], 16'h0000, rd, ae, ve, ak);
      check("gap read", {ak, ae, ve, rd}, {3'h6, 16'h0000});
    end
    rdc(SMP_A_MAXF, 16'h0FA0);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // hang guard, well above the roughly 600 cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      wrap_up();
    end
  end

  initial begin
    rst = 1'b1;
    start_freq = 16'h0064;
    high_volt_class = 1'b0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    $display("reset values done");
    t_codes();
    $display("code sets done");
    t_ranges();
    $display("ranges done");
    t_wide();
    $display("wide values done");
    t_gaps();
    $display("reserved gaps done");
    wrap_up();
  end
endmodule
